// [core/ivc_pin_sync.sv]
`timescale 1ns/100ps
`include "ivc_params.svh"

module ivc_pin_sync #(
    parameter int N = `IVC_N_PIN
) (
    input wire logic clk,
    input wire logic rstn,
    ivc_src_if.sync_mp src
);
    import ivc_pkg::*;

    logic [N-1:0] s1_ff;
    logic [N-1:0] s2_ff;
    logic [N-1:0] s3_ff;
    logic [N-1:0] lvl_ff;
    logic [N-1:0] edge_ff;
    logic [N-1:0] nxt_lvl;
    logic [N-1:0] nxt_edge;

    // ======================================================
    // Per pin filter: a level counts once stages two and three agree
    for (genvar i = 0; i < N; i++) begin : g_pin
        assign nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
        // Rising edge is the valid edge for every pin
        assign nxt_edge[i] = nxt_lvl[i] & ~lvl_ff[i];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
            edge_ff <= '0;
        end else begin
            s1_ff <= src.pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
            edge_ff <= nxt_edge;
        end
    end

    assign src.pin_edge = edge_ff;

endmodule : ivc_pin_sync

// [core/ivc_prio_enc.sv]
`timescale 1ns/100ps
`include "ivc_params.svh"

module ivc_prio_enc #(
    parameter int N = `IVC_N_MASK,
    parameter int W = `IVC_IDX_W
) (
    ivc_src_if.enc_mp src
);
    import ivc_pkg::*;

    // ======================================================
    // Lowest index wins; scanning downward lets it overwrite
    always_comb begin
        logic valid;
        logic [W-1:0] idx;
        valid = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (src.pend[i]) begin
                valid = 1'b1;
                idx = W'(i); // RULE1
            end
        end
        src.grant_valid = valid;
        src.grant_idx = idx;
    end

endmodule : ivc_prio_enc

// [core/ivc_vector_controller.sv]
// Operation
// RULE1: Simultaneous maskables: lowest priority number wins
// RULE2: Any reset vectors code 0000, handler zero
// RULE3: Non-maskable pin edge gives code 0010
// RULE4: Watchdog non-maskables give codes 0020 and 0030
// RULE5: Watchdog non-maskable service ends in reset
// RULE6: Trap vector n gives 004n or 005n
// RULE7: Illegal op code or debug trap: 0060
// RULE8: Illegal op code saves offending address plus four
// RULE9: Interval watchdog and edge pins: priorities 0-7
// RULE10: Timer matches: priorities 8-13, 0100-0150
// RULE11: Serial sources: priorities 14-25, 0160-0210
// RULE12: Remaining sources: priorities 26-30, 0220-0260
// RULE13: Save restored PC in matching save register
// RULE14: Abortable instruction restarts after service
// RULE15: Non-maskables ignore mask, beat maskables
`timescale 1ns/100ps
`include "ivc_params.svh"

module ivc_vector_controller #(
    parameter int N_PERIPH = 23
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_pin,
    input wire logic nmi_pin,
    input wire logic [6:0] edge_pin,
    input wire logic watchdog_a_reset,
    input wire logic watchdog_b_reset,
    input wire logic watchdog_a_nonmaskable,
    input wire logic watchdog_b_nonmaskable,
    input wire logic watchdog_interval_request,
    input wire logic [N_PERIPH-1:0] periph_request,
    input wire logic trap_req,
    input wire logic trap_group_high,
    input wire logic [3:0] trap_vector,
    input wire logic illegal_opcode_trap,
    input wire logic debug_trap,
    input wire logic [31:0] current_instr_address,
    input wire logic [31:0] following_instruction_address,
    input wire logic abortable_instr,
    input wire logic mask_all,
    input wire logic return_from_interrupt,
    output logic vec_valid_ff,
    output ivc_pkg::ivc_kind_t vec_kind_ff,
    output logic [15:0] exc_code_ff,
    output logic [31:0] handler_ff,
    output logic [31:0] restored_pc_ff,
    output logic pc_defined_ff,
    output logic [31:0] interrupt_save_pc_ff,
    output logic [31:0] nonmaskable_save_pc_ff
);
    import ivc_pkg::*;

    // ======================================================
    // Declarations
    ivc_state_t state_ff, nxt_state;
    logic [`IVC_N_MASK-1:0] mask_pend_ff, nxt_mask_pend, mask_set;
    logic [2:0] nmi_pend_ff, nxt_nmi_pend, nmi_set;
    logic wdt_nmi_ff, nxt_wdt_nmi, nxt_vec_valid, nxt_pc_defined;
    ivc_kind_t nxt_vec_kind;
    logic [15:0] nxt_exc_code;
    logic [31:0] nxt_handler, nxt_restored_pc, nxt_int_save, nxt_nmi_save, int_pc;
    logic reset_any, exc_any, nmi_ok, mask_ok;
    logic take_exc, take_nmi, take_mask;

    // ======================================================
    // Pin filtering and maskable priority resolution
    ivc_src_if #(
        .NPIN(`IVC_N_PIN),
        .NMASK(`IVC_N_MASK),
        .IDXW(`IVC_IDX_W)
    ) src_if ();

    assign src_if.pin_raw = {edge_pin, nmi_pin, reset_pin};
    assign src_if.pend = mask_pend_ff;

    ivc_pin_sync #(
        .N(`IVC_N_PIN)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .src(src_if.sync_mp)
    );

    ivc_prio_enc #(
        .N(`IVC_N_MASK),
        .W(`IVC_IDX_W)
    ) u_enc (
        .src(src_if.enc_mp)
    );

    // ======================================================
    // Source mapping: index equals default priority
    assign mask_set = {periph_request,
                       src_if.pin_edge[`IVC_N_PIN-1:`IVC_PIN_EDGE_LSB],
                       watchdog_interval_request}; // RULE9 RULE10 RULE11 RULE12
    assign nmi_set = {watchdog_b_nonmaskable, watchdog_a_nonmaskable,
                      src_if.pin_edge[`IVC_PIN_NMI]};
    assign reset_any = src_if.pin_edge[`IVC_PIN_RESET] | watchdog_a_reset
                       | watchdog_b_reset;
    assign exc_any = trap_req | illegal_opcode_trap | debug_trap;
    // Aborted instructions are re-run, so their own address is saved
    assign int_pc = abortable_instr ? current_instr_address
                                    : following_instruction_address; // RULE14

    // ======================================================
    // Acceptance and vector selection
    always_comb begin
        nxt_state = state_ff;
        nxt_wdt_nmi = wdt_nmi_ff;
        nmi_ok = 1'b0;
        mask_ok = 1'b0;
        case (state_ff)
            IVC_IDLE: begin
                nmi_ok = 1'b1;
                mask_ok = !mask_all;
            end
            IVC_SERVICE: begin
                nmi_ok = 1'b1; // RULE15
                if (return_from_interrupt) begin
                    nxt_state = IVC_IDLE;
                end
            end
            IVC_NMI_SVC: begin
                // A watchdog non-maskable never returns; only reset leaves
                if (return_from_interrupt && !wdt_nmi_ff) begin // RULE5
                    nxt_state = IVC_IDLE;
                end
            end
            default: begin
                nxt_state = IVC_IDLE;
            end
        endcase

        take_exc = !reset_any && exc_any;
        take_nmi = !reset_any && !exc_any && nmi_ok && (|nmi_pend_ff);
        take_mask = !reset_any && !exc_any && !(nmi_ok && (|nmi_pend_ff))
                    && mask_ok && src_if.grant_valid; // RULE15

        nxt_vec_valid = 1'b0;
        nxt_vec_kind = vec_kind_ff;
        nxt_exc_code = exc_code_ff;
        nxt_handler = handler_ff;
        nxt_restored_pc = restored_pc_ff;
        nxt_pc_defined = pc_defined_ff;
        nxt_int_save = interrupt_save_pc_ff;
        nxt_nmi_save = nonmaskable_save_pc_ff;
        nxt_mask_pend = (mask_pend_ff & ~mask_clr_f(take_mask, src_if.grant_idx))
                        | mask_set;
        nxt_nmi_pend = nmi_pend_ff | nmi_set;

        if (reset_any) begin
            nxt_vec_valid = 1'b1;
            nxt_vec_kind = IVC_K_RESET;
            nxt_exc_code = `IVC_CODE_RESET; // RULE2
            nxt_handler = `IVC_HND_RESET; // RULE2
            nxt_restored_pc = `IVC_RST_WORD;
            nxt_pc_defined = 1'b0; // RULE2
            nxt_state = IVC_IDLE;
            nxt_wdt_nmi = 1'b0;
            // Arrivals in the same cycle survive the reset clear
            nxt_mask_pend = mask_set;
            nxt_nmi_pend = nmi_set;
        end else if (take_exc) begin
            nxt_vec_valid = 1'b1;
            nxt_vec_kind = IVC_K_EXC;
            nxt_pc_defined = 1'b1;
            if (illegal_opcode_trap) begin
                nxt_exc_code = `IVC_CODE_EXC_TRAP; // RULE7
                nxt_handler = `IVC_HND_EXC_TRAP; // RULE7
                nxt_restored_pc = current_instr_address
                                  + `IVC_ILLEGAL_OPCODE_TRAP_PC_OFS; // RULE8
            end else if (debug_trap) begin
                nxt_exc_code = `IVC_CODE_EXC_TRAP; // RULE7
                nxt_handler = `IVC_HND_EXC_TRAP; // RULE7
                nxt_restored_pc = following_instruction_address;
            end else if (trap_group_high) begin
                nxt_exc_code = {`IVC_CODE_TRAP_HI, trap_vector}; // RULE6
                nxt_handler = `IVC_HND_TRAP_HI; // RULE6
                nxt_restored_pc = following_instruction_address;
            end else begin
                nxt_exc_code = {`IVC_CODE_TRAP_LO, trap_vector}; // RULE6
                nxt_handler = `IVC_HND_TRAP_LO; // RULE6
                nxt_restored_pc = following_instruction_address;
            end
            nxt_int_save = nxt_restored_pc; // RULE13
            if (state_ff == IVC_IDLE) begin
                nxt_state = IVC_SERVICE;
            end
        end else if (take_nmi) begin
            nxt_vec_valid = 1'b1;
            nxt_vec_kind = IVC_K_NMI;
            nxt_pc_defined = 1'b1;
            nxt_restored_pc = int_pc;
            nxt_nmi_save = int_pc; // RULE13
            nxt_state = IVC_NMI_SVC;
            if (nmi_pend_ff[`IVC_NMI_PIN_BIT]) begin
                nxt_exc_code = `IVC_CODE_NMI_PIN; // RULE3
                nxt_handler = `IVC_HND_NMI_PIN; // RULE3
                nxt_nmi_pend[`IVC_NMI_PIN_BIT] = nmi_set[`IVC_NMI_PIN_BIT];
                nxt_wdt_nmi = 1'b0;
            end else if (nmi_pend_ff[`IVC_NMI_A_BIT]) begin
                nxt_exc_code = `IVC_CODE_WDT_A; // RULE4
                nxt_handler = `IVC_HND_WDT_A; // RULE4
                nxt_nmi_pend[`IVC_NMI_A_BIT] = nmi_set[`IVC_NMI_A_BIT];
                nxt_wdt_nmi = 1'b1;
            end else begin
                nxt_exc_code = `IVC_CODE_WDT_B; // RULE4
                nxt_handler = `IVC_HND_WDT_B; // RULE4
                nxt_nmi_pend[`IVC_NMI_B_BIT] = nmi_set[`IVC_NMI_B_BIT];
                nxt_wdt_nmi = 1'b1;
            end
        end else if (take_mask) begin
            nxt_vec_valid = 1'b1;
            nxt_vec_kind = IVC_K_MASK;
            nxt_pc_defined = 1'b1;
            nxt_exc_code = mask_code_f(src_if.grant_idx); // RULE9 RULE10 RULE11 RULE12
            nxt_handler = {16'h0000, nxt_exc_code}; // RULE9
            nxt_restored_pc = int_pc;
            nxt_int_save = int_pc; // RULE13
            nxt_state = IVC_SERVICE;
        end
    end

    // ======================================================
    // Helpers
    function automatic logic [15:0] mask_code_f(input logic [`IVC_IDX_W-1:0] idx);
        mask_code_f = `IVC_CODE_MASK_BASE + {7'h00, idx, 4'h0};
    endfunction : mask_code_f

    // Clear only the granted bit; a new arrival re-sets it after
    function automatic logic [`IVC_N_MASK-1:0] mask_clr_f(
        input logic take,
        input logic [`IVC_IDX_W-1:0] idx
    );
        mask_clr_f = '0;
        mask_clr_f[idx] = take;
    endfunction : mask_clr_f

    // ======================================================
    // Registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= IVC_IDLE;
            mask_pend_ff <= '0;
            nmi_pend_ff <= '0;
            wdt_nmi_ff <= 1'b0;
            vec_valid_ff <= 1'b0;
            vec_kind_ff <= IVC_K_NONE;
            exc_code_ff <= `IVC_RST_CODE;
            handler_ff <= `IVC_RST_WORD;
            restored_pc_ff <= `IVC_RST_WORD;
            pc_defined_ff <= 1'b0;
            interrupt_save_pc_ff <= `IVC_RST_WORD;
            nonmaskable_save_pc_ff <= `IVC_RST_WORD;
        end else begin
            state_ff <= nxt_state;
            mask_pend_ff <= nxt_mask_pend;
            nmi_pend_ff <= nxt_nmi_pend;
            wdt_nmi_ff <= nxt_wdt_nmi;
            vec_valid_ff <= nxt_vec_valid;
            vec_kind_ff <= nxt_vec_kind;
            exc_code_ff <= nxt_exc_code;
            handler_ff <= nxt_handler;
            restored_pc_ff <= nxt_restored_pc;
            pc_defined_ff <= nxt_pc_defined;
            interrupt_save_pc_ff <= nxt_int_save;
            nonmaskable_save_pc_ff <= nxt_nmi_save;
        end
    end

    // ======================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_mask_lowest_wins: assert property ( // RULE1
        take_mask |-> ((mask_pend_ff & ~({`IVC_N_MASK{1'b1}}
            << src_if.grant_idx)) == '0) && mask_pend_ff[src_if.grant_idx])
        else $error("maskable grant not lowest pending");
    a_reset_vector: assert property ( // RULE2
        reset_any |=> vec_valid_ff && vec_kind_ff == IVC_K_RESET
            && exc_code_ff == `IVC_CODE_RESET && handler_ff == `IVC_HND_RESET
            && !pc_defined_ff && state_ff == IVC_IDLE)
        else $error("reset did not vector to zero");
    a_nmi_pin_code: assert property ( // RULE3
        take_nmi && nmi_pend_ff[`IVC_NMI_PIN_BIT] |=>
            exc_code_ff == `IVC_CODE_NMI_PIN && handler_ff == `IVC_HND_NMI_PIN)
        else $error("pin non-maskable wrong vector");
    a_wdt_nmi_code: assert property ( // RULE4
        take_nmi && !nmi_pend_ff[`IVC_NMI_PIN_BIT] |=> $past(nmi_pend_ff[`IVC_NMI_A_BIT])
            ? (exc_code_ff == `IVC_CODE_WDT_A && handler_ff == `IVC_HND_WDT_A)
            : (exc_code_ff == `IVC_CODE_WDT_B && handler_ff == `IVC_HND_WDT_B))
        else $error("watchdog non-maskable wrong vector");
    a_wdt_no_return: assert property ( // RULE5
        state_ff == IVC_NMI_SVC && wdt_nmi_ff && !reset_any
            |=> state_ff == IVC_NMI_SVC)
        else $error("watchdog service left without reset");
    a_trap_code: assert property ( // RULE6
        trap_req && !reset_any && !illegal_opcode_trap && !debug_trap |=>
            exc_code_ff[3:0] == $past(trap_vector)
            && exc_code_ff[15:4] == ($past(trap_group_high) ? `IVC_CODE_TRAP_HI
                                                          : `IVC_CODE_TRAP_LO))
        else $error("trap code mismatch");
    a_exc_trap_code: assert property ( // RULE7
        (illegal_opcode_trap || debug_trap) && !reset_any |=>
            exc_code_ff == `IVC_CODE_EXC_TRAP && handler_ff == `IVC_HND_EXC_TRAP)
        else $error("exception trap wrong vector");
    a_illegal_opcode_trap_pc: assert property ( // RULE8
        illegal_opcode_trap && !reset_any |=>
            restored_pc_ff - `IVC_ILLEGAL_OPCODE_TRAP_PC_OFS == $past(current_instr_address))
        else $error("illegal op code restored pc wrong");
    a_mask_vector: assert property ( // RULE9 RULE10 RULE11 RULE12
        take_mask |=> vec_kind_ff == IVC_K_MASK && handler_ff[31:16] == 16'h0000
            && handler_ff[15:0] == exc_code_ff
            && exc_code_ff == `IVC_CODE_MASK_BASE
               + {7'h00, $past(src_if.grant_idx), 4'h0})
        else $error("maskable vector mismatch");
    a_save_select: assert property ( // RULE13
        vec_valid_ff && vec_kind_ff == IVC_K_NMI |->
            nonmaskable_save_pc_ff == restored_pc_ff ##1
            $stable(interrupt_save_pc_ff) || vec_valid_ff)
        else $error("non-maskable save register not used");
    a_abort_resume: assert property ( // RULE14
        (take_nmi || take_mask) && abortable_instr |=>
            restored_pc_ff == $past(current_instr_address))
        else $error("aborted instruction not resumed");
    a_nmi_beats_mask: assert property ( // RULE15
        !reset_any && !exc_any && (|nmi_pend_ff) && state_ff != IVC_NMI_SVC
            |-> !take_mask ##1 vec_kind_ff == IVC_K_NMI)
        else $error("maskable taken over non-maskable");

    c_mask_taken: cover property (take_mask ##[1:8] return_from_interrupt);
    c_nmi_over_mask: cover property (take_nmi && src_if.grant_valid);
    c_trap_high: cover property (take_exc && trap_req && trap_group_high);
    c_wdt_then_reset: cover property (state_ff == IVC_NMI_SVC && wdt_nmi_ff
        ##[1:20] reset_any);

endmodule : ivc_vector_controller

// [pkg/ivc_params.svh]
`ifndef IVC_PARAMS_SVH
`define IVC_PARAMS_SVH

// ==========================================================
// Source counts and widths
`define IVC_N_PIN 9
`define IVC_N_MASK 31
`define IVC_IDX_W 5
`define IVC_PIN_RESET 0
`define IVC_PIN_NMI 1
`define IVC_PIN_EDGE_LSB 2
`define IVC_NMI_PIN_BIT 0
`define IVC_NMI_A_BIT 1
`define IVC_NMI_B_BIT 2

// ==========================================================
// Exception codes and handler addresses
`define IVC_CODE_RESET 16'h0000
`define IVC_HND_RESET 32'h0000_0000
`define IVC_CODE_NMI_PIN 16'h0010
`define IVC_HND_NMI_PIN 32'h0000_0010
`define IVC_CODE_WDT_A 16'h0020
`define IVC_HND_WDT_A 32'h0000_0020
`define IVC_CODE_WDT_B 16'h0030
`define IVC_HND_WDT_B 32'h0000_0030
`define IVC_CODE_TRAP_LO 12'h004
`define IVC_HND_TRAP_LO 32'h0000_0040
`define IVC_CODE_TRAP_HI 12'h005
`define IVC_HND_TRAP_HI 32'h0000_0050
`define IVC_CODE_EXC_TRAP 16'h0060
`define IVC_HND_EXC_TRAP 32'h0000_0060
`define IVC_CODE_MASK_BASE 16'h0080
`define IVC_ILLEGAL_OPCODE_TRAP_PC_OFS 32'h0000_0004

// ==========================================================
// Reset values
`define IVC_RST_CODE 16'h0000
`define IVC_RST_WORD 32'h0000_0000

`endif

// [pkg/ivc_pkg.sv]
package ivc_pkg;

    // ======================================================
    // Controller states, Gray along idle-service-nmi
    typedef enum logic [1:0] {
        IVC_IDLE = 2'b00,
        IVC_SERVICE = 2'b01,
        IVC_NMI_SVC = 2'b11
    } ivc_state_t;

    // ======================================================
    // Class of the vector last issued
    typedef enum logic [2:0] {
        IVC_K_NONE = 3'h0,
        IVC_K_RESET = 3'h1,
        IVC_K_NMI = 3'h2,
        IVC_K_EXC = 3'h3,
        IVC_K_MASK = 3'h4
    } ivc_kind_t;

endpackage : ivc_pkg

// [pkg/ivc_src_if.sv]
`timescale 1ns/100ps
`include "ivc_params.svh"

interface ivc_src_if #(
    parameter int NPIN = `IVC_N_PIN,
    parameter int NMASK = `IVC_N_MASK,
    parameter int IDXW = `IVC_IDX_W
);
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_edge;
    logic [NMASK-1:0] pend;
    logic grant_valid;
    logic [IDXW-1:0] grant_idx;

    modport sync_mp (input pin_raw, output pin_edge);
    modport enc_mp (input pend, output grant_valid, output grant_idx);
    modport ctl_mp (output pin_raw, output pend, input pin_edge,
                    input grant_valid, input grant_idx);
endinterface : ivc_src_if

// [tb/ivc_core_model.sv]
`timescale 1ns/100ps

module ivc_core_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic vec_valid,
    input wire ivc_pkg::ivc_kind_t vec_kind,
    input wire logic [15:0] exc_code,
    input wire logic [31:0] handler,
    output logic [31:0] current_instr_address,
    output logic [31:0] following_instruction_address,
    output logic return_from_interrupt
);
    import ivc_pkg::*;
    // ======================================================
    // Core program counter and return timing
    logic [31:0] pc_ff;
    logic [31:0] nxt_pc;
    logic [2:0] ret_cnt_ff;
    logic [2:0] nxt_ret_cnt;
    logic ret_ok;

    // Watchdog non-maskables never return; only a reset leaves them
    assign ret_ok = (vec_kind != IVC_K_RESET)
                    && ((vec_kind != IVC_K_NMI) || (exc_code == 16'h0010));
    // Short instructions: next address is two on, so save offsets are visible
    assign current_instr_address = pc_ff;
    assign following_instruction_address = pc_ff + 32'h0000_0002;
    assign return_from_interrupt = (ret_cnt_ff == 3'h1);

    always_comb begin
        nxt_pc = pc_ff;
        nxt_ret_cnt = (ret_cnt_ff != 3'h0) ? ret_cnt_ff - 3'h1 : 3'h0;
        if (vec_valid) begin
            nxt_pc = handler;
            nxt_ret_cnt = ret_ok ? 3'h4 : 3'h0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_ff <= 32'h0000_1000;
            ret_cnt_ff <= 3'h0;
        end else begin
            pc_ff <= nxt_pc;
            ret_cnt_ff <= nxt_ret_cnt;
        end
    end
endmodule : ivc_core_model

// [tb/ivc_vector_controller_bench.sv]
`timescale 1ns/100ps

module ivc_vector_controller_bench;
    import ivc_pkg::*;
    logic clk, rstn, reset_pin, nmi_pin, trap_req, trap_group_high, illegal_opcode_trap;
    logic watchdog_a_reset, watchdog_b_reset, watchdog_a_nonmaskable, watchdog_b_nonmaskable;
    logic watchdog_interval_request, debug_trap, abortable_instr, mask_all;
    logic return_from_interrupt, vec_valid_ff, pc_defined_ff;
    logic [6:0] edge_pin;
    logic [22:0] periph_request;
    logic [3:0] trap_vector;
    logic [15:0] exc_code_ff;
    logic [31:0] current_instr_address, following_instruction_address, handler_ff;
    logic [31:0] restored_pc_ff, interrupt_save_pc_ff, nonmaskable_save_pc_ff;
    ivc_kind_t vec_kind_ff;
    int fails, n_checks, cnt;

    ivc_vector_controller #(.N_PERIPH(23)) ivc_vector_controller_inst (.clk, .rstn,
        .reset_pin, .nmi_pin, .edge_pin, .watchdog_a_reset, .watchdog_b_reset,
        .watchdog_a_nonmaskable, .watchdog_b_nonmaskable, .watchdog_interval_request,
        .periph_request, .trap_req, .trap_group_high, .trap_vector, .illegal_opcode_trap,
        .debug_trap, .current_instr_address, .following_instruction_address, .abortable_instr,
        .mask_all, .return_from_interrupt, .vec_valid_ff, .vec_kind_ff, .exc_code_ff,
        .handler_ff, .restored_pc_ff, .pc_defined_ff, .interrupt_save_pc_ff,
        .nonmaskable_save_pc_ff);

    ivc_core_model ivc_core_model_inst (.clk, .rstn, .vec_valid(vec_valid_ff),
        .vec_kind(vec_kind_ff), .exc_code(exc_code_ff), .handler(handler_ff),
        .current_instr_address, .following_instruction_address, .return_from_interrupt);

    // ======================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic fire(input int s, input int b);
        @(negedge clk);
        case (s)
            0: watchdog_a_reset = 1'b1;
            1: watchdog_b_reset = 1'b1;
            2: watchdog_a_nonmaskable = 1'b1;
            3: watchdog_b_nonmaskable = 1'b1;
            4: watchdog_interval_request = 1'b1;
            5: trap_req = 1'b1;
            6: illegal_opcode_trap = 1'b1;
            7: debug_trap = 1'b1;
            8: periph_request[b] = 1'b1;
            10: reset_pin = 1'b1;
            11: nmi_pin = 1'b1;
            12: edge_pin[b] = 1'b1;
            default: ;
        endcase
        if (s < 10) begin
            @(negedge clk);
            {watchdog_a_reset, watchdog_b_reset, watchdog_a_nonmaskable} = 3'h0;
            {watchdog_b_nonmaskable, watchdog_interval_request, trap_req} = 3'h0;
            {illegal_opcode_trap, debug_trap} = 2'h0;
            periph_request = 23'h0;
        end
    endtask : fire

    // Expected restored pc is the core address at accept plus ofs
    task automatic expect_vec(input ivc_kind_t k, input logic [15:0] code,
                              input logic [31:0] hnd, input logic [31:0] ofs);
        int i;
        i = 0;
        while (vec_valid_ff !== 1'b1 && i < 14) begin
            @(negedge clk);
            i++;
        end
        chk({31'h0, vec_valid_ff}, 32'h1);
        chk({29'h0, vec_kind_ff}, {29'h0, k});
        chk({16'h0, exc_code_ff}, {16'h0, code});
        chk(handler_ff, hnd);
        if (k == IVC_K_RESET) begin
            chk({31'h0, pc_defined_ff}, 32'h0);
        end else begin
            chk({31'h0, pc_defined_ff}, 32'h1);
            chk(restored_pc_ff, current_instr_address + ofs);
            chk(k == IVC_K_NMI ? nonmaskable_save_pc_ff : interrupt_save_pc_ff,
                current_instr_address + ofs);
        end
    endtask : expect_vec

    task automatic go(input int s, input int b, input ivc_kind_t k, input logic [15:0] code,
                      input logic [31:0] hnd, input logic [31:0] ofs);
        fire(s, b);
        expect_vec(k, code, hnd, ofs);
        {reset_pin, nmi_pin, edge_pin} = 9'h0;
        repeat (7) @(negedge clk);
    endtask : go

    // ======================================================
    // Clock, reset, watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #1_000_000;
        fails++;
        complete_run();
    end

    // ======================================================
    // Scenarios
    task automatic run_resets;
        go(0, 0, IVC_K_RESET, 16'h0000, 32'h0, 32'h0);
        go(10, 0, IVC_K_RESET, 16'h0000, 32'h0, 32'h0);
        go(11, 0, IVC_K_NMI, 16'h0010, 32'h10, 32'h2);
        go(2, 0, IVC_K_NMI, 16'h0020, 32'h20, 32'h2);
        go(1, 0, IVC_K_RESET, 16'h0000, 32'h0, 32'h0);
        go(3, 0, IVC_K_NMI, 16'h0030, 32'h30, 32'h2);
        go(0, 0, IVC_K_RESET, 16'h0000, 32'h0, 32'h0);
    endtask : run_resets

    task automatic run_traps;
        for (int n = 0; n < 32; n++) begin
            trap_group_high = n[4];
            trap_vector = n[3:0];
            go(5, 0, IVC_K_EXC, 16'h0040 + 16'(n), n[4] ? 32'h50 : 32'h40, 32'h2);
        end
        go(6, 0, IVC_K_EXC, 16'h0060, 32'h60, 32'h4);
        go(7, 0, IVC_K_EXC, 16'h0060, 32'h60, 32'h2);
    endtask : run_traps

    task automatic run_maskables;
        for (int k = 0; k < 31; k++) begin
            go(k == 0 ? 4 : (k < 8 ? 12 : 8), k < 8 ? k - 1 : k - 8, IVC_K_MASK,
               16'h0080 + 16'(k * 16), 32'h80 + 32'(k * 16), 32'h2);
        end
        // Three maskables in one cycle are served in default order
        @(negedge clk);
        {watchdog_interval_request, periph_request[22], periph_request[5]} = 3'h7;
        @(negedge clk);
        {watchdog_interval_request, periph_request[22], periph_request[5]} = 3'h0;
        expect_vec(IVC_K_MASK, 16'h0080, 32'h80, 32'h2);
        @(negedge clk);
        expect_vec(IVC_K_MASK, 16'h0150, 32'h150, 32'h2);
        @(negedge clk);
        expect_vec(IVC_K_MASK, 16'h0260, 32'h260, 32'h2);
        repeat (7) @(negedge clk);
    endtask : run_maskables

    task automatic run_precedence;
        // Masked request waits while a pin non-maskable still gets through
        mask_all = 1'b1;
        fire(8, 0);
        cnt = 0;
        repeat (10) begin
            @(negedge clk);
            cnt += (vec_valid_ff === 1'b1);
        end
        chk(cnt, 0);
        fire(11, 0);
        expect_vec(IVC_K_NMI, 16'h0010, 32'h10, 32'h2);
        nmi_pin = 1'b0;
        mask_all = 1'b0;
        @(negedge clk);
        expect_vec(IVC_K_MASK, 16'h0100, 32'h100, 32'h2);
        repeat (7) @(negedge clk);
        abortable_instr = 1'b1;
        go(8, 3, IVC_K_MASK, 16'h0130, 32'h130, 32'h0);
        abortable_instr = 1'b0;
        // Unmasked maskable and non-maskable in one cycle: non-maskable first
        @(negedge clk);
        {watchdog_b_nonmaskable, periph_request[1]} = 2'h3;
        @(negedge clk);
        {watchdog_b_nonmaskable, periph_request[1]} = 2'h0;
        expect_vec(IVC_K_NMI, 16'h0030, 32'h30, 32'h2);
    endtask : run_precedence

    initial begin
        {rstn, reset_pin, nmi_pin, trap_req, trap_group_high, illegal_opcode_trap} = 6'h0;
        {watchdog_a_reset, watchdog_b_reset, watchdog_a_nonmaskable} = 3'h0;
        {watchdog_b_nonmaskable, watchdog_interval_request, debug_trap} = 3'h0;
        {abortable_instr, mask_all, edge_pin, periph_request, trap_vector} = 36'h0;
        fails = 0;
        n_checks = 0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        run_resets();
        run_traps();
        run_maskables();
        run_precedence();
        complete_run();
    end
endmodule : ivc_vector_controller_bench
